// file: inc/scdma_pkg.sv
// scdma_pkg: constants, register map and carrier types of the single channel dma control block
// assumes a 32-bit ahb-lite register bus and a 16-bit single-clock system bus port
package scdma_pkg;

    // widths
    localparam int ADDR_W = 24;
    localparam int CNT_W = 16;
    localparam int DATA_W = 16;

    // register byte offsets
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_SRC = 8'h08;
    localparam logic [7:0] OFF_DST = 8'h0C;
    localparam logic [7:0] OFF_FC = 8'h10;
    localparam logic [7:0] OFF_COUNT = 8'h14;
    localparam logic [7:0] OFF_VECTOR = 8'h18;
    localparam logic [7:0] OFF_PEND = 8'h1C;

    // channel_mode_register fields
    localparam int MB_START = 0;
    localparam int MB_EXT = 1;
    localparam int MB_NIE = 2;
    localparam int MB_EIE = 3;
    localparam int MB_SINC = 4;
    localparam int MB_DINC = 5;
    localparam int MB_WORD = 6;
    localparam int MB_DEVDST = 7;
    localparam logic [7:0] MODE_RST = 8'h00;

    // channel_status_register fields
    localparam int SB_CNT_DONE = 0;
    localparam int SB_DEV_DONE = 1;
    localparam int SB_DST_BERR = 2;
    localparam int SB_SRC_BERR = 3;
    localparam int SB_BUSY = 4;
    localparam logic [3:0] STATUS_RST = 4'h0;

    // function_code_register fields
    localparam int FB_SRC_LO = 0;
    localparam int FB_DST_LO = 4;
    localparam logic [5:0] FC_RST = 6'h00;

    // vector register fields
    localparam int VB_HI_LO = 5;
    localparam int VB_HANDLER_LO = 8;
    localparam logic [4:0] VEC_SRC_CODE = 5'h0B;
    localparam int VEC_SCALE_SHIFT = 2;
    localparam logic [2:0] VEC_HI_RST = 3'h0;

    // operand steps
    localparam logic [ADDR_W-1:0] STEP_BYTE = 24'h000001;
    localparam logic [ADDR_W-1:0] STEP_WORD = 24'h000002;

    // one system bus cycle request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [2:0] fc;
        logic write;
        logic word;
        logic [DATA_W-1:0] wdata;
    } scdma_cyc_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARB,
        ST_RD,
        ST_WR,
        ST_REL
    } scdma_state_type;

endpackage

// file: hw/scdma_sync.sv
// scdma_sync: two-flop synchroniser for pin inputs
// assumes level inputs that stay stable for several hclk periods
`timescale 1ns/100ps
module scdma_sync #(
    parameter int W = 2
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // pins and synchronised levels
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign level_out = sync_q;
endmodule

// file: hw/scdma_channel.sv
// scdma_channel: control of one independent transfer channel with ahb-lite registers
// assumes one bus master on hclk, a system bus port on hclk and asynchronous request/end pins
`timescale 1ns/100ps
//
// Contract
// - end input seen at the device cycle ends the channel after that operand, sets device done.
// - on end-input termination clear start; interrupt only with normal enable set.
// - end-input termination still decrements count and advances pointers.
// - end input also terminates internally generated transfer sequences.
// - bus error aborts the cycle, ends channel, clears start, sets source or dest flag.
// - after bus error, interrupt only when error enable is set.
// - transfers begin only after software sets the start bit.
// - while started, pointers, function codes and count read but ignore writes.
// - once started, accept peripheral requests (external) or self-generate them (internal).
// - first valid external request after start causes arbitration for the bus.
// - peripheral request input ignored while start bit is clear.
// - start bit clears at count zero, end input, or bus error.
// - software clearing start finishes the operand, releases bus, starts no more cycles.
// - setting start again with a pending request arbitrates and resumes.
// - mode register holds separate normal and error interrupt enables.
// - with the matching enable clear, only status updates, no pending bit.
// - with matching enable set, the event sets the channel pending bit.
// - vector joins three programmed upper bits with source code 01011.
// - handler address is the eight-bit vector times four.
module scdma_channel import scdma_pkg::*; (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // peripheral pins
    input wire logic peripheral_transfer_request,
    input wire logic end_of_transfer,
    // system bus master port
    output logic bus_request,
    input wire logic bus_grant,
    output logic cyc_valid,
    output scdma_cyc_type cyc,
    input wire logic transfer_acknowledge_input,
    input wire logic cyc_berr,
    input wire logic [DATA_W-1:0] cyc_rdata,
    // interrupt controller
    output logic irq_pending,
    output logic [7:0] irq_vector
);
    function automatic logic [ADDR_W-1:0] step_of(input logic word);
        step_of = word ? STEP_WORD : STEP_BYTE;
    endfunction

    // bus slave state
    logic acc_q;
    logic acc_wr_q;
    logic [7:0] acc_addr_q;
    logic hready_q;
    logic [31:0] hrdata_q;
    logic [31:0] rd_val;
    logic wr_en;

    // registers
    logic [7:0] mode_q;
    logic [3:0] status_q;
    logic [ADDR_W-1:0] src_q;
    logic [ADDR_W-1:0] dst_q;
    logic [CNT_W-1:0] cnt_q;
    logic [5:0] fc_q;
    logic [2:0] vec_hi_q;
    logic irq_pend_q;
    logic [7:0] irq_vector_q;

    // channel state
    scdma_state_type state_q;
    logic bus_req_q;
    logic cyc_valid_q;
    scdma_cyc_type cyc_q;
    logic eot_hit_q;
    logic treq_d_q;
    logic req_pend_q;
    logic [1:0] pins_s;
    logic treq_s;
    logic eot_s;

    // events
    logic start;
    logic want_op;
    logic op_take;
    logic rd_fin;
    logic wr_fin;
    logic end_count;
    logic end_dev;
    logic end_err;
    logic end_any;
    logic [CNT_W-1:0] cnt_dec;
    logic [3:0] st_set;
    logic irq_set;

    scdma_sync #(.W(2)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in({end_of_transfer, peripheral_transfer_request}),
        .level_out(pins_s)
    );
    assign treq_s = pins_s[0];
    assign eot_s = pins_s[1];

    // ahb-lite slave: one wait state, then registered read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_q <= 1'b0;
            acc_wr_q <= 1'b0;
            acc_addr_q <= 8'h00;
            hready_q <= 1'b1;
            hrdata_q <= 32'h00000000;
        end else if (acc_q) begin
            acc_q <= 1'b0;
            hready_q <= 1'b1;
            if (!acc_wr_q) begin
                hrdata_q <= rd_val;
            end
        end else if (hsel && hready && htrans[1]) begin
            acc_q <= 1'b1;
            acc_wr_q <= hwrite;
            acc_addr_q <= haddr[7:0];
            hready_q <= 1'b0;
        end
    end

    assign wr_en = acc_q && acc_wr_q;

    // register read decode
    always_comb begin
        rd_val = 32'h00000000;
        if (acc_addr_q == OFF_MODE) begin
            rd_val[7:0] = mode_q;
        end else if (acc_addr_q == OFF_STATUS) begin
            rd_val[3:0] = status_q;
            rd_val[SB_BUSY] = (state_q != ST_IDLE);
        end else if (acc_addr_q == OFF_SRC) begin
            rd_val[ADDR_W-1:0] = src_q;
        end else if (acc_addr_q == OFF_DST) begin
            rd_val[ADDR_W-1:0] = dst_q;
        end else if (acc_addr_q == OFF_FC) begin
            rd_val[FB_SRC_LO +: 3] = fc_q[2:0];
            rd_val[FB_DST_LO +: 3] = fc_q[5:3];
        end else if (acc_addr_q == OFF_COUNT) begin
            rd_val[CNT_W-1:0] = cnt_q;
        end else if (acc_addr_q == OFF_VECTOR) begin
            rd_val[7:0] = irq_vector_q;
            rd_val[VB_HANDLER_LO +: 10] = {irq_vector_q, 2'b00} << 0;
        end else if (acc_addr_q == OFF_PEND) begin
            rd_val[0] = irq_pend_q;
        end
    end

    // channel events
    assign start = mode_q[MB_START];
    assign want_op = start && (mode_q[MB_EXT] ? req_pend_q : 1'b1);
    assign op_take = (state_q == ST_ARB) && bus_grant && start;
    assign rd_fin = (state_q == ST_RD) && transfer_acknowledge_input && !cyc_berr;
    assign wr_fin = (state_q == ST_WR) && transfer_acknowledge_input && !cyc_berr;
    assign cnt_dec = cnt_q - CNT_W'(step_of(mode_q[MB_WORD]));
    assign end_count = wr_fin && (cnt_dec == '0);
    assign end_dev = wr_fin && (eot_hit_q || (mode_q[MB_DEVDST] && eot_s));
    assign end_err = ((state_q == ST_RD) || (state_q == ST_WR)) && cyc_berr;
    assign end_any = end_count || end_dev || end_err;

    always_comb begin
        st_set = 4'h0;
        st_set[SB_CNT_DONE] = end_count;
        st_set[SB_DEV_DONE] = end_dev;
        st_set[SB_DST_BERR] = end_err && (state_q == ST_WR);
        st_set[SB_SRC_BERR] = end_err && (state_q == ST_RD);
    end

    // event to pending bit only through the matching enable
    assign irq_set = ((end_count || end_dev) && mode_q[MB_NIE]) || (end_err && mode_q[MB_EIE]);

    // channel_mode_register; hardware clear of start wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= MODE_RST;
        end else begin
            if (wr_en && acc_addr_q == OFF_MODE) begin
                mode_q <= hwdata[7:0];
            end
            if (end_any) begin
                mode_q[MB_START] <= 1'b0;
            end
        end
    end

    // channel_status_register: write one to clear, set wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_q <= STATUS_RST;
        end else if (wr_en && acc_addr_q == OFF_STATUS) begin
            status_q <= (status_q & ~hwdata[3:0]) | st_set;
        end else begin
            status_q <= status_q | st_set;
        end
    end

    // pointers, count and function codes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_q <= '0;
            dst_q <= '0;
            cnt_q <= '0;
            fc_q <= FC_RST;
        end else if (wr_fin) begin
            cnt_q <= cnt_dec;
            if (mode_q[MB_SINC]) begin
                src_q <= src_q + step_of(mode_q[MB_WORD]);
            end
            if (mode_q[MB_DINC]) begin
                dst_q <= dst_q + step_of(mode_q[MB_WORD]);
            end
        end else if (wr_en && !start) begin
            if (acc_addr_q == OFF_SRC) begin
                src_q <= hwdata[ADDR_W-1:0];
            end else if (acc_addr_q == OFF_DST) begin
                dst_q <= hwdata[ADDR_W-1:0];
            end else if (acc_addr_q == OFF_COUNT) begin
                cnt_q <= hwdata[CNT_W-1:0];
            end else if (acc_addr_q == OFF_FC) begin
                fc_q <= {hwdata[FB_DST_LO +: 3], hwdata[FB_SRC_LO +: 3]};
            end
        end
    end

    // pending bit and vector
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_pend_q <= 1'b0;
            vec_hi_q <= VEC_HI_RST;
            irq_vector_q <= {VEC_HI_RST, VEC_SRC_CODE};
        end else begin
            if (wr_en && acc_addr_q == OFF_PEND && hwdata[0]) begin
                irq_pend_q <= irq_set;
            end else if (irq_set) begin
                irq_pend_q <= 1'b1;
            end
            if (wr_en && acc_addr_q == OFF_VECTOR) begin
                vec_hi_q <= hwdata[VB_HI_LO +: 3];
            end
            irq_vector_q <= {vec_hi_q, VEC_SRC_CODE};
        end
    end

    // external request edge, held across suspend
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            treq_d_q <= 1'b0;
            req_pend_q <= 1'b0;
        end else begin
            treq_d_q <= treq_s;
            if (start && mode_q[MB_EXT] && treq_s && !treq_d_q) begin
                req_pend_q <= 1'b1;
            end else if (op_take) begin
                req_pend_q <= 1'b0;
            end
        end
    end

    // transfer sequencer: arbitrate, read source, write destination, release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_IDLE;
            bus_req_q <= 1'b0;
            cyc_valid_q <= 1'b0;
            cyc_q <= '0;
            eot_hit_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (want_op) begin
                        bus_req_q <= 1'b1;
                        state_q <= ST_ARB;
                    end
                end
                ST_ARB: begin
                    if (!start) begin
                        state_q <= ST_REL;
                    end else if (bus_grant) begin
                        cyc_valid_q <= 1'b1;
                        cyc_q.addr <= src_q;
                        cyc_q.fc <= fc_q[2:0];
                        cyc_q.write <= 1'b0;
                        cyc_q.word <= mode_q[MB_WORD];
                        eot_hit_q <= 1'b0;
                        state_q <= ST_RD;
                    end
                end
                ST_RD: begin
                    if (cyc_berr) begin
                        cyc_valid_q <= 1'b0;
                        state_q <= ST_REL;
                    end else if (transfer_acknowledge_input) begin
                        eot_hit_q <= !mode_q[MB_DEVDST] && eot_s;
                        cyc_q.addr <= dst_q;
                        cyc_q.fc <= fc_q[5:3];
                        cyc_q.write <= 1'b1;
                        cyc_q.wdata <= cyc_rdata;
                        state_q <= ST_WR;
                    end
                end
                ST_WR: begin
                    if (cyc_berr || transfer_acknowledge_input) begin
                        cyc_valid_q <= 1'b0;
                        state_q <= ST_REL;
                    end
                end
                ST_REL: begin
                    bus_req_q <= 1'b0;
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign hreadyout = hready_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign bus_request = bus_req_q;
    assign cyc_valid = cyc_valid_q;
    assign cyc = cyc_q;
    assign irq_pending = irq_pend_q;
    assign irq_vector = irq_vector_q;

    dev_done_a: assert property (@(posedge hclk) disable iff (!hresetn)
        end_dev |=> status_q[SB_DEV_DONE] && !start)
        else $error("device end did not set done or clear start");

    end_irq_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (end_dev && !end_err && !mode_q[MB_NIE] && !irq_pend_q) |=> !irq_pend_q)
        else $error("pending set without normal enable");

    count_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_fin |=> cnt_q == $past(cnt_dec))
        else $error("count not decremented on operand");

    berr_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (end_err && state_q == ST_RD) |=> status_q[SB_SRC_BERR] && !start ##1 !bus_req_q)
        else $error("source bus error not handled");

    err_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (end_err && mode_q[MB_EIE]) |=> irq_pend_q)
        else $error("error interrupt not pending");

    ptr_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_en && start && acc_addr_q == OFF_SRC && !wr_fin) |=> $stable(src_q))
        else $error("source pointer written while started");

    arb_req_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_q == ST_IDLE && want_op) |=> bus_req_q && state_q == ST_ARB)
        else $error("no arbitration after request");

    req_ignore_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !start |=> !$rose(req_pend_q))
        else $error("request taken while stopped");

    stop_cycles_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_q == ST_ARB && !start) |=> !cyc_valid_q ##1 !bus_req_q && state_q == ST_IDLE)
        else $error("cycle started while stopped");

    vector_code_a: assert property (@(posedge hclk) disable iff (!hresetn)
        irq_vector_q == {$past(vec_hi_q), VEC_SRC_CODE})
        else $error("vector code wrong");

    release_a: assert property (@(posedge hclk) disable iff (!hresetn)
        end_any |=> state_q == ST_REL ##1 (!bus_req_q && state_q == ST_IDLE))
        else $error("bus not released after termination");
endmodule

// file: dv/scdma_bus_model.sv
// scdma_bus_model: system bus partner that grants the bus and answers channel cycles
// assumes the channel holds cyc_valid and cyc until an ack or bus error pulse
`timescale 1ns/100ps
module scdma_bus_model import scdma_pkg::*; (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bench controls
    input wire logic stall_grant,
    input wire logic [1:0] dly,
    input wire logic [1:0] berr_sel,
    // channel side
    input wire logic bus_request,
    output logic bus_grant,
    input wire logic cyc_valid,
    input wire scdma_cyc_type cyc,
    output logic ack,
    output logic berr,
    output logic [DATA_W-1:0] rdata
);
    logic [1:0] wait_q;
    logic hit;
    // bus error on the read cycle (1) or the write cycle (2)
    assign hit = (berr_sel == 2'h1 && !cyc.write) || (berr_sel == 2'h2 && cyc.write);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_grant <= 1'b0;
        end else begin
            bus_grant <= bus_request && !stall_grant;
        end
    end
    // read data is only valid with the ack, it toggles otherwise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ack <= 1'b0;
            berr <= 1'b0;
            wait_q <= 2'h0;
            rdata <= 16'hA5A5;
        end else begin
            ack <= 1'b0;
            berr <= 1'b0;
            rdata <= ~rdata;
            if (cyc_valid && !ack && !berr) begin
                if (wait_q == dly) begin
                    wait_q <= 2'h0;
                    berr <= hit;
                    ack <= !hit;
                    rdata <= cyc.addr[15:0] ^ 16'h3C5A;
                end else begin
                    wait_q <= wait_q + 2'h1;
                end
            end
        end
    end
endmodule

// file: dv/tb_single_channel_dma_control.sv
// tb_single_channel_dma_control: self-checking bench for the dma channel control
// assumes scdma_pkg, the channel design and the bus model are compiled first
`timescale 1ns/100ps
module tb_single_channel_dma_control;
    import scdma_pkg::*;
    localparam logic [31:0] P_ST = 32'h1 << MB_START;
    localparam logic [31:0] P_EX = 32'h1 << MB_EXT;
    localparam logic [31:0] P_NIE = 32'h1 << MB_NIE;
    localparam logic [31:0] P_EE = 32'h1 << MB_EIE;
    localparam logic [31:0] P_INC = (32'h1 << MB_SINC) | (32'h1 << MB_DINC);
    localparam logic [31:0] P_WD = 32'h1 << MB_WORD;
    localparam logic [31:0] P_DV = 32'h1 << MB_DEVDST;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, preq, eot, stall;
    logic [31:0] haddr, hwdata, hrdata, rv, s, d, e, m, be;
    logic [15:0] wd;
    logic [1:0] htrans, dly, bsel;
    logic bus_request, bus_grant, cyc_valid, ack, berr, irq_pending, dp, dp_rd;
    scdma_cyc_type cyc;
    logic [DATA_W-1:0] rdata;
    logic [7:0] irq_vector, vec;
    logic [31:0] q_exp[$];
    logic [31:0] q_msk[$];
    int failures, n_compared, cycles, i;
    scdma_channel uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .peripheral_transfer_request(preq), .end_of_transfer(eot),
        .bus_request(bus_request), .bus_grant(bus_grant), .cyc_valid(cyc_valid), .cyc(cyc),
        .transfer_acknowledge_input(ack), .cyc_berr(berr), .cyc_rdata(rdata),
        .irq_pending(irq_pending), .irq_vector(irq_vector));
    scdma_bus_model sbus (.hclk(hclk), .hresetn(hresetn), .stall_grant(stall), .dly(dly), .berr_sel(bsel),
        .bus_request(bus_request), .bus_grant(bus_grant), .cyc_valid(cyc_valid), .cyc(cyc), .ack(ack),
        .berr(berr), .rdata(rdata));
    always #10 hclk = ~hclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("compared=%0d failures=%0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // takes the oldest note whenever a read data phase ends
    always @(negedge hclk) begin
        if (dp && hreadyout) begin
            if (dp_rd && q_exp.size() > 0) begin
                e = q_exp.pop_front();
                m = q_msk.pop_front();
                if (m != 32'h0) chk(hrdata & m, e & m);
            end
            dp = 1'b0;
        end
        if (!dp && hresetn && hsel && htrans[1] && hreadyout) begin
            dp = 1'b1;
            dp_rd = !hwrite;
        end
    end
    // each destination write carries the data its source read returned
    always @(negedge hclk) begin
        if (cyc_valid && ack && !cyc.write) wd = rdata;
        if (cyc_valid && ack && cyc.write) chk(cyc.wdata, wd);
    end
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("[FAIL] t=%0t timeout seen=%h exp=%h", $time, cycles, 0);
            test_done();
        end
    end
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] dat);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(negedge hclk); while (hreadyout !== 1'b1);
        @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= dat;
        do @(negedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata;
        @(posedge hclk);
        hsel <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        acc(1'b1, a, dat);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        q_exp.push_back(exp);
        q_msk.push_back(32'hFFFFFFFF);
        acc(1'b0, a, 32'h0);
    endtask
    task automatic poll(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] v);
        int k;
        for (k = 0; k < 100; k++) begin
            q_exp.push_back(32'h0);
            q_msk.push_back(32'h0);
            acc(1'b0, a, 32'h0);
            if ((rv & msk) === v) break;
        end
        if (k == 100) begin
            failures++;
            $display("[FAIL] t=%0t poll seen=%h exp=%h", $time, rv, v);
        end
    endtask
    task automatic setup(input logic [31:0] cnt);
        wr(OFF_SRC, s);
        wr(OFF_DST, d);
        wr(OFF_COUNT, cnt);
        wr(OFF_STATUS, 32'h1F);
        wr(OFF_PEND, 32'h1);
    endtask
    task automatic pulse();
        @(posedge hclk);
        preq <= 1'b1;
        repeat (4) @(posedge hclk);
        preq <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        {hsel, hwrite, preq, eot, stall, dp, dp_rd} = 7'h00;
        {haddr, hwdata} = 64'h0;
        {htrans, dly, bsel} = 6'h00;
        failures = 0;
        n_compared = 0;
        cycles = 0;
        rv = $urandom(49);
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rd(OFF_MODE, 32'h0);
        rd(OFF_PEND, 32'h0);
        rd(8'h20, 32'h0);
        for (i = 0; i < 8; i++) begin
            vec = {i[2:0], VEC_SRC_CODE};
            if (i > 0) wr(OFF_VECTOR, {24'h000000, i[2:0], 5'h00});
            rd(OFF_VECTOR, {14'h0000, vec, 2'h0, vec});
            chk(irq_vector, vec);
        end
        $display("test vector done");
        s = $urandom & 32'h007FFF00;
        d = $urandom & 32'h007FFF00;
        dly <= 2'h3;
        setup(32'h4);
        wr(OFF_MODE, P_ST | P_INC | P_WD | P_NIE);
        poll(OFF_COUNT, 32'hFFFF, 32'h0);
        poll(OFF_STATUS, 32'h10, 32'h0);
        rd(OFF_STATUS, 32'h1);
        rd(OFF_SRC, s + 32'h4);
        rd(OFF_DST, d + 32'h4);
        rd(OFF_MODE, P_INC | P_WD | P_NIE);
        rd(OFF_PEND, 32'h1);
        chk(irq_pending, 32'h1);
        wr(OFF_PEND, 32'h1);
        rd(OFF_PEND, 32'h0);
        $display("test internal done");
        dly <= 2'h0;
        setup(32'h5);
        wr(OFF_MODE, P_EX | P_INC);
        pulse();
        rd(OFF_COUNT, 32'h5);
        wr(OFF_MODE, P_EX | P_INC | P_ST);
        wr(OFF_SRC, 32'h0);
        wr(OFF_COUNT, 32'h0);
        rd(OFF_SRC, s);
        rd(OFF_COUNT, 32'h5);
        stall <= 1'b1;
        pulse();
        rd(OFF_STATUS, 32'h10);
        wr(OFF_MODE, P_EX | P_INC);
        stall <= 1'b0;
        repeat (20) @(posedge hclk);
        rd(OFF_COUNT, 32'h5);
        wr(OFF_MODE, P_EX | P_INC | P_ST);
        poll(OFF_COUNT, 32'hFFFF, 32'h4);
        rd(OFF_SRC, s + 32'h1);
        wr(OFF_MODE, 32'h0);
        $display("test suspend done");
        setup(32'h5);
        eot <= 1'b1;
        wr(OFF_MODE, P_EX | P_INC | P_ST);
        pulse();
        poll(OFF_STATUS, 32'h12, 32'h2);
        rd(OFF_STATUS, 32'h2);
        rd(OFF_COUNT, 32'h4);
        rd(OFF_SRC, s + 32'h1);
        rd(OFF_DST, d + 32'h1);
        rd(OFF_MODE, P_EX | P_INC);
        rd(OFF_PEND, 32'h0);
        setup(32'h3);
        wr(OFF_MODE, P_DV | P_INC | P_NIE | P_ST);
        poll(OFF_STATUS, 32'h12, 32'h2);
        rd(OFF_COUNT, 32'h2);
        rd(OFF_PEND, 32'h1);
        eot <= 1'b0;
        $display("test end input done");
        for (i = 1; i < 3; i++) begin
            setup(32'h3);
            bsel <= i[1:0];
            dly <= 2'($urandom);
            wr(OFF_MODE, P_INC | P_ST | ((i == 1) ? P_EE : 32'h0));
            be = (i == 1) ? 32'h8 : 32'h4;
            poll(OFF_STATUS, 32'h1C, be);
            rd(OFF_STATUS, be);
            rd(OFF_COUNT, 32'h3);
            rd(OFF_MODE, P_INC | ((i == 1) ? P_EE : 32'h0));
            rd(OFF_PEND, (i == 1) ? 32'h1 : 32'h0);
            chk(irq_pending, (i == 1) ? 32'h1 : 32'h0);
            chk(bus_request, 32'h0);
            bsel <= 2'h0;
        end
        $display("test bus error done");
        test_done();
    end
endmodule
